//--- bench/afe_properties.sv
// Purpose: Port checks of the measurement control block
// Assumes: One clock, reset active low
// Notes:   Bound onto the top module
`timescale 1ns/1ps
module afe_properties (
  input wire       CLK_IN,
  input wire       RST_N_IN,
  input wire [5:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire       REG_WR_IN,
  input wire       CONV_DONE_IN,
  input wire       CONV_REQ_OUT,
  input wire       CONV_COMPLETE_OUT,
  input wire       CLOCK_RUN_OUT,
  input wire       SRC_TEMP_OUT,
  input wire       SRC_AMP_OUT,
  input wire       SRC_AUX_OUT,
  input wire       LADDER_TO_TIA_SWITCH_OUT,
  input wire       LADDER_TO_POTENTIOSTAT_SWITCH_OUT,
  input wire       TIA_SENSOR_INPUT_SELECT_OUT,
  input wire       POTENTIOSTAT_SENSOR_INPUT_SELECT_OUT,
  input wire       LADDER_OUTPUT_SELECT_OUT,
  input wire       GAIN_STAGE_ENABLE_OUT,
  input wire [2:0] TIA_BIAS_TAP_OUT,
  input wire [4:0] POTENTIOSTAT_BIAS_TAP_OUT,
  input wire       BIAS_LADDER_POWER_OUT,
  input wire       TIA_POWER_OUT,
  input wire       POTENTIOSTAT_POWER_OUT,
  input wire       OSCILLATOR_POWER_OUT,
  input wire       ELECTRODE_SHORTING_SWITCH_OUT,
  input wire       SENSOR_DIAGNOSTIC_OUT,
  input wire       INTERNAL_REFERENCE_SWITCH_OUT,
  input wire       GAIN_STAGE_TOPOLOGY_OUT,
  input wire [1:0] GAIN_STAGE_GAIN_OUT
);
  wire [3:0] pwr = {BIAS_LADDER_POWER_OUT, TIA_POWER_OUT, POTENTIOSTAT_POWER_OUT,
                    OSCILLATOR_POWER_OUT};
  wire [5:0] blk = {REG_WDATA_IN[6:3], REG_WDATA_IN[1:0]};
  wire [3:0] path = {TIA_SENSOR_INPUT_SELECT_OUT, POTENTIOSTAT_SENSOR_INPUT_SELECT_OUT,
                     LADDER_OUTPUT_SELECT_OUT, GAIN_STAGE_ENABLE_OUT};
  wire       wr_ok = REG_WR_IN && CLOCK_RUN_OUT;
  wire       wr_blk = REG_WR_IN && REG_ADDR_IN == 6'h13;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_done;
    CONV_REQ_OUT && CONV_DONE_IN;
  endsequence
  sequence s_pulse;
    ##1 CONV_COMPLETE_OUT ##1 !CONV_COMPLETE_OUT;
  endsequence
  a_src_decode: assert property (
    REG_WR_IN && REG_ADDR_IN == 6'h00 |=> ##1 {SRC_AUX_OUT, SRC_AMP_OUT, SRC_TEMP_OUT}
    == (3'h1 << $past(REG_WDATA_IN[2:1], 2))) else $error("source decode wrong");
  a_req_drop: assert property (
    s_done |=> !CONV_REQ_OUT) else $error("request held after done");
  a_complete_pulse: assert property (
    s_done |=> s_pulse) else $error("completion pulse wrong");
  a_ladder_switch: assert property (
    wr_ok && REG_ADDR_IN == 6'h0F |=> {LADDER_TO_TIA_SWITCH_OUT,
    LADDER_TO_POTENTIOSTAT_SWITCH_OUT} == $past(REG_WDATA_IN[5:4])) else $error("switch wrong");
  a_bias_taps: assert property (
    wr_ok && REG_ADDR_IN == 6'h10 |=> {TIA_BIAS_TAP_OUT, POTENTIOSTAT_BIAS_TAP_OUT}
    == $past(REG_WDATA_IN)) else $error("bias taps wrong");
  a_path_select: assert property (
    wr_ok && REG_ADDR_IN == 6'h11 |=> path == $past({REG_WDATA_IN[6:5], REG_WDATA_IN[3:2]}))
    else $error("input path wrong");
  a_power_bits: assert property (
    wr_ok && REG_ADDR_IN == 6'h12 |=> pwr == $past(REG_WDATA_IN[7:4]))
    else $error("power bits wrong");
  a_stopped_ignore: assert property (
    REG_WR_IN && !CLOCK_RUN_OUT && !CONV_REQ_OUT && REG_ADDR_IN == 6'h12 |=> $stable(pwr))
    else $error("write taken while stopped");
  a_block_fields: assert property (
    wr_blk |=> {GAIN_STAGE_GAIN_OUT, CLOCK_RUN_OUT, GAIN_STAGE_TOPOLOGY_OUT,
    SENSOR_DIAGNOSTIC_OUT, ELECTRODE_SHORTING_SWITCH_OUT} == $past(blk))
    else $error("block control wrong");
  a_ref_switch: assert property (
    wr_blk |=> ##1 INTERNAL_REFERENCE_SWITCH_OUT == !$past(REG_WDATA_IN[2], 2))
    else $error("reference switch wrong");
endmodule
bind afe_measurement_control afe_properties u_afe_properties (.*);

//--- bench/conv_model.sv
// Purpose: Converter stand-in answering conversion requests
// Assumes: Done is a one-cycle pulse, data valid only with it
// Notes:   Data lines toggle while not valid
`timescale 1ns/1ps
module conv_model (
  input  wire        clk_in,
  input  wire        req_in,
  input  wire [7:0]  lat_in,
  input  wire [15:0] val_in,
  output reg         done_out,
  output reg  [15:0] data_out
);
  reg [7:0] cnt_r;
  initial begin
    done_out = 1'b0;
    data_out = 16'h0000;
    cnt_r    = 8'h00;
  end
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    data_out <= ~data_out;
    cnt_r    <= 8'h00;
    if (req_in && !done_out) begin
      if (cnt_r == lat_in) begin
        done_out <= 1'b1;
        data_out <= val_in;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule

//--- bench/tb_afe_measurement_control.sv
// Purpose: Self-checking bench of the measurement control block
// Assumes: Host register strobes and converter model on one clock
// Notes:   Register image kept in an integer array
`timescale 1ns/1ps
module tb_afe_measurement_control;
  reg         clk;
  reg         rst_n;
  reg  [5:0]  addr;
  reg  [7:0]  wdata;
  reg         wr_en;
  reg         rd;
  wire [1:0]  csrc;
  wire [7:0]  rdata;
  wire        done;
  wire [15:0] cdata;
  wire        req;
  reg  [7:0]  lat;
  reg  [15:0] val;
  reg  [31:0] lfsr;
  reg  [5:0]  a;
  integer     n_fail;
  integer     cmp_count;
  integer     cyc = 0;
  integer     mdl [0:63];
  integer     i;
  integer     n_done;
  integer     k;
  afe_measurement_control u_afe_measurement_control (
    .CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr_en), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CONV_DONE_IN(done),
    .CONV_DATA_IN(cdata), .CONV_REQ_OUT(req), .CONV_SRC_OUT(csrc), .CONV_COMPLETE_OUT(),
    .CLOCK_RUN_OUT(), .SRC_TEMP_OUT(), .SRC_AMP_OUT(), .SRC_AUX_OUT(),
    .LADDER_TO_TIA_SWITCH_OUT(), .LADDER_TO_POTENTIOSTAT_SWITCH_OUT(),
    .TIA_SENSOR_INPUT_SELECT_OUT(), .POTENTIOSTAT_SENSOR_INPUT_SELECT_OUT(),
    .LADDER_OUTPUT_SELECT_OUT(), .GAIN_STAGE_ENABLE_OUT(), .TIA_BIAS_TAP_OUT(),
    .POTENTIOSTAT_BIAS_TAP_OUT(), .BIAS_LADDER_POWER_OUT(), .TIA_POWER_OUT(),
    .POTENTIOSTAT_POWER_OUT(), .OSCILLATOR_POWER_OUT(), .ELECTRODE_SHORTING_SWITCH_OUT(),
    .SENSOR_DIAGNOSTIC_OUT(), .INTERNAL_REFERENCE_SWITCH_OUT(),
    .GAIN_STAGE_TOPOLOGY_OUT(), .GAIN_STAGE_GAIN_OUT());
  conv_model u_conv_model (.clk_in(clk), .req_in(req), .lat_in(lat), .val_in(val),
    .done_out(done), .data_out(cdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  task chk(input [8*8-1:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("FAIL %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task do_reset;
    begin
      for (i = 0; i < 64; i = i + 1)
        mdl[i] = 0;
      mdl[19] = 8'h10;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
    end
  endtask
  task wr(input [5:0] wa, input [7:0] d);
    begin
      @(posedge clk);
      #1 addr = wa;
      wdata = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1 wr_en = 1'b0;
      if (wa == 6'h00)
        mdl[0] = d & 8'h0F;
      else if (wa == 6'h13)
        mdl[19] = d & 8'h7F;
      else if (mdl[19][4] && wa >= 6'h0F && wa <= 6'h12)
        mdl[wa] = d;
    end
  endtask
  task rd_op(input [5:0] ra);
    begin
      @(posedge clk);
      #1 addr = ra;
      rd = 1'b1;
      @(posedge clk);
      #1 rd = 1'b0;
    end
  endtask
  task rdc(input [5:0] ra);
    begin
      rd_op(ra);
      chk("reg", {8'h00, rdata}, mdl[ra]);
    end
  endtask
  task conv(input [1:0] s, input [7:0] l);
    integer n;
    integer o;
    begin
      lfsr = nxt(lfsr);
      val = lfsr[15:0];
      lat = l;
      wr(6'h00, {4'h1, s, 1'b0});
      for (n = 0; n < 300; n = n + 1) begin
        rd_op(6'h00);
        chk("src", {13'h0000, rdata[2:0]}, {13'h0000, s, 1'b0});
        if (rdata[3] === 1'b0)
          n = 300;
      end
      mdl[0] = {5'h00, s, 1'b0};
      rdc(6'h00);
      chk("csrc", {14'h0000, csrc}, {14'h0000, s});
      o = s == 2'h1 ? 2 : s == 2'h2 ? 4 : 6;
      mdl[o] = val[7:0];
      mdl[o + 1] = s == 2'h0 ? val[9:8] : val[15:8];
      for (n = 0; n < 8; n = n + 1)
        rdc(n[5:0]);
      chk("req", {15'h0000, req}, 16'h0000);
    end
  endtask
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd = 1'b0;
    lat = 8'h00;
    val = 16'h0000;
    lfsr = 32'hEBE2;
    n_fail = 0;
    cmp_count = 0;
    do_reset;
    for (k = 0; k < 64; k = k + 1)
      rdc(k[5:0]);
    $display("test reset values done");
    wr(6'h13, 8'h00);
    wr(6'h12, 8'hF0);
    rdc(6'h12);
    wr(6'h13, 8'h10);
    wr(6'h12, 8'hF0);
    rdc(6'h12);
    wr(6'h12, 8'h70);
    rdc(6'h12);
    for (k = 0; k < 40; k = k + 1) begin
      lfsr = nxt(lfsr);
      a = lfsr[3] ? 6'h0F + lfsr[6:4] % 3'h5 : lfsr[13:8];
      if (a == 6'h00)
        a = 6'h13;
      wr(a, lfsr[23:16]);
      rdc(a);
    end
    $display("test config done");
    for (k = 0; k < 4; k = k + 1) begin
      wr(6'h13, 8'h10 | k[7:0] << 5 | k[7:0] << 2 | k[7:0]);
      rdc(6'h13);
    end
    $display("test block control done");
    for (k = 0; k < 8; k = k + 1)
      conv(2'(k % 3), k < 3 ? 8'h00 : k < 6 ? 8'hC8 : 8'h05);
    $display("test conversions done");
    lfsr = nxt(lfsr);
    val = lfsr[15:0];
    lat = 8'h05;
    wr(6'h00, 8'h09);
    n_done = 0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (done)
        n_done = n_done + 1;
    end
    chk("reps", {15'h0000, n_done > 1}, 16'h0001);
    rdc(6'h00);
    wr(6'h00, 8'h00);
    repeat (20) @(posedge clk);
    mdl[6] = val[7:0];
    mdl[7] = val[9:8];
    for (k = 0; k < 8; k = k + 1)
      rdc(k[5:0]);
    chk("req", {15'h0000, req}, 16'h0000);
    $display("test repeat mode done");
    do_reset;
    for (k = 0; k < 20; k = k + 1)
      rdc(k[5:0]);
    $display("test second reset done");
    close_out;
  end
endmodule

//--- rtl/afe_consts.vh
// Purpose: Shared offsets, field positions and reset values
// Assumes: Byte-wide registers on a 6-bit register address
// Notes:   Definitions only
`ifndef AFE_CONSTS_VH
`define AFE_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MEASUREMENT_CONTROL  6'h00
`define OFS_AMP_RESULT_LOW       6'h02
`define OFS_AMP_RESULT_HIGH      6'h03
`define OFS_AUX_RESULT_LOW       6'h04
`define OFS_AUX_RESULT_HIGH      6'h05
`define OFS_TEMP_RESULT_LOW      6'h06
`define OFS_TEMP_RESULT_HIGH     6'h07
`define OFS_BIAS_SWITCH_CONNECT  6'h0F
`define OFS_BIAS_LEVEL_SELECT    6'h10
`define OFS_INPUT_PATH_CONNECT   6'h11
`define OFS_BLOCK_POWER_CONTROL  6'h12
`define OFS_BLOCK_CONTROL_REG    6'h13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_MODE                 0
`define BIT_SRC_LO               1
`define BIT_SRC_HI               2
`define BIT_START                3
`define BIT_LADDER_TO_TIA        5
`define BIT_LADDER_TO_POT        4
`define BIT_TIA_SENSOR_SEL       6
`define BIT_POT_SENSOR_SEL       5
`define BIT_LADDER_OUT_SEL       3
`define BIT_GAIN_STAGE_EN            2
`define BIT_PWR_LADDER           7
`define BIT_PWR_TIA              6
`define BIT_PWR_POT              5
`define BIT_PWR_OSCILLATOR       4
`define BIT_SHORT_SWITCH         0
`define BIT_DIAGNOSTIC           1
`define BIT_BIAS_REF_SEL         2
`define BIT_TOPOLOGY             3
`define BIT_CLOCK_RUN            4
`define BIT_GAIN_LO              5
`define BIT_GAIN_HI              6

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define SRC_TEMP                 2'h0
`define SRC_AMP                  2'h1
`define SRC_AUX                  2'h2
`define TEMP_RESULT_BITS         10
`define RST_BYTE                 8'h00
`define RST_BLOCK_CONTROL        8'h10
`define RST_RESULT               16'h0000

`endif

//--- rtl/afe_measurement_control.v
// Purpose: Register file and measurement sequencing of the sensor front end
// Assumes: Host register port and converter handshake on CLK_IN
// Notes:   Analog controls are plain register-driven levels
// Summary of operation
// RULE1: Source code 00 routes temperature sensor
// RULE2: Source code 01 routes amplifier path
// RULE3: Source code 10 routes auxiliary input via gain_stage
// RULE4: Mode bit 0 gives one conversion per start
// RULE5: Start bit self-clears when conversion completes; the code clears it only with mode bit 0
// RULE6: Temperature result 10 bits at 0x06/0x07
// RULE7: Amplifier result 16 bits at 0x02/0x03
// RULE8: Auxiliary result 16 bits at 0x04/0x05
// RULE9: Bit 5 closes ladder to transimpedance switch
// RULE10: Bit 4 closes ladder to potentiostat switch
// RULE11: Bit 6 selects sensor into transimpedance amp
// RULE12: Bit 5 sensor or ground on potentiostat input
// RULE13: Bit 3 ladder/aux select, bit 2 gain_stage enable
// RULE14: Bias taps from bits 7:5 and 4:0
// RULE15: Upper power bits power analog blocks
// RULE16: Control bit drives electrode shorting switch
// RULE17: Diagnostic bit offsets the transimpedance amp
// RULE18: Reference select 0 closes internal reference switch
// RULE19: Topology bit picks non-inverting or instrumentation
// RULE20: Two-bit gain code selects 1,2,4,8
// RULE21: Clock stopped idle accepts only two registers
// RULE22: Results hold until same source completes again
`timescale 1ns/1ps
`include "afe_consts.vh"

module afe_measurement_control (
  input  wire        CLK_IN,
  input  wire        RST_N_IN,
  input  wire [5:0]  REG_ADDR_IN,
  input  wire [7:0]  REG_WDATA_IN,
  input  wire        REG_WR_IN,
  input  wire        REG_RD_IN,
  output reg  [7:0]  REG_RDATA_OUT,
  input  wire        CONV_DONE_IN,
  input  wire [15:0] CONV_DATA_IN,
  output wire        CONV_REQ_OUT,
  output wire [1:0]  CONV_SRC_OUT,
  output reg         CONV_COMPLETE_OUT,
  output wire        CLOCK_RUN_OUT,
  output reg         SRC_TEMP_OUT,
  output reg         SRC_AMP_OUT,
  output reg         SRC_AUX_OUT,
  output wire        LADDER_TO_TIA_SWITCH_OUT,
  output wire        LADDER_TO_POTENTIOSTAT_SWITCH_OUT,
  output wire        TIA_SENSOR_INPUT_SELECT_OUT,
  output wire        POTENTIOSTAT_SENSOR_INPUT_SELECT_OUT,
  output wire        LADDER_OUTPUT_SELECT_OUT,
  output wire        GAIN_STAGE_ENABLE_OUT,
  output wire [2:0]  TIA_BIAS_TAP_OUT,
  output wire [4:0]  POTENTIOSTAT_BIAS_TAP_OUT,
  output wire        BIAS_LADDER_POWER_OUT,
  output wire        TIA_POWER_OUT,
  output wire        POTENTIOSTAT_POWER_OUT,
  output wire        OSCILLATOR_POWER_OUT,
  output wire        ELECTRODE_SHORTING_SWITCH_OUT,
  output wire        SENSOR_DIAGNOSTIC_OUT,
  output reg         INTERNAL_REFERENCE_SWITCH_OUT,
  output wire        GAIN_STAGE_TOPOLOGY_OUT,
  output wire [1:0]  GAIN_STAGE_GAIN_OUT
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [7:0]  measurement_control_r;
  reg  [7:0]  bias_switch_connect_r;
  reg  [7:0]  bias_level_select_r;
  reg  [7:0]  input_path_connect_r;
  reg  [7:0]  block_power_control_r;
  reg  [7:0]  block_control_r;
  reg  [15:0] amp_result_r;
  reg  [15:0] aux_result_r;
  reg  [9:0]  temp_result_r;

  // ----------------------------------------
  // Internal nets
  // ----------------------------------------
  wire        seq_done;
  wire        seq_busy;
  wire        write_allowed;
  wire        clock_stopped;
  wire        sel_control;
  wire        sel_block_control;
  wire [1:0]  source_select;
  wire        conversion_mode_bit;
  wire        conversion_start;
  wire        seq_start;
  reg  [7:0]  rdata_nxt;
  wire        cfg_write;
  wire [2:0]  src_match;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  assign source_select       = measurement_control_r[`BIT_SRC_HI:`BIT_SRC_LO];
  assign conversion_mode_bit = measurement_control_r[`BIT_MODE];
  assign conversion_start    = measurement_control_r[`BIT_START];

  assign sel_control       = (REG_ADDR_IN == `OFS_MEASUREMENT_CONTROL);
  assign sel_block_control = (REG_ADDR_IN == `OFS_BLOCK_CONTROL_REG);

  // Clock considered stopped while idle with the run bit low
  assign clock_stopped = !seq_busy && !block_control_r[`BIT_CLOCK_RUN];
  assign write_allowed = !clock_stopped || sel_control
                         || sel_block_control; // [RULE21]

  // Configuration writes that the clock state lets through
  assign cfg_write     = REG_WR_IN && write_allowed; // [RULE21]

  // Start a new conversion only when none is running
  assign seq_start = conversion_start && !seq_busy && !seq_done;

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  conv_sequencer u_seq (
    .clk_in       (CLK_IN),
    .rst_n_in     (RST_N_IN),
    .start_in     (seq_start),
    .source_in    (source_select),
    .conv_done_in (CONV_DONE_IN),
    .conv_req_out (CONV_REQ_OUT),
    .conv_src_out (CONV_SRC_OUT),
    .done_out     (seq_done),
    .busy_out     (seq_busy)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      measurement_control_r <= `RST_BYTE;
    end else begin
      if (REG_WR_IN && sel_control) begin
        measurement_control_r <= {4'h0, REG_WDATA_IN[3:0]};
      end else if (seq_done && !conversion_mode_bit) begin
        // Host write in the same cycle wins over this clear
        measurement_control_r[`BIT_START] <= 1'b0; // [RULE4] [RULE5]
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bias_switch_connect_r <= `RST_BYTE;
      bias_level_select_r   <= `RST_BYTE;
      input_path_connect_r  <= `RST_BYTE;
      block_power_control_r <= `RST_BYTE;
      block_control_r       <= `RST_BLOCK_CONTROL;
    end else if (cfg_write) begin // [RULE21]
      case (REG_ADDR_IN)
        `OFS_BIAS_SWITCH_CONNECT: begin
          bias_switch_connect_r <= REG_WDATA_IN;
        end
        `OFS_BIAS_LEVEL_SELECT: begin
          bias_level_select_r <= REG_WDATA_IN;
        end
        `OFS_INPUT_PATH_CONNECT: begin
          input_path_connect_r <= REG_WDATA_IN;
        end
        `OFS_BLOCK_POWER_CONTROL: begin
          block_power_control_r <= REG_WDATA_IN;
        end
        `OFS_BLOCK_CONTROL_REG: begin
          block_control_r <= {1'b0, REG_WDATA_IN[6:0]};
        end
        default: begin
          block_control_r <= block_control_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      amp_result_r  <= `RST_RESULT;
      aux_result_r  <= `RST_RESULT;
      temp_result_r <= 10'h000;
    end else if (seq_busy && CONV_DONE_IN) begin
      // Only the source that was converted is updated
      case (CONV_SRC_OUT)
        `SRC_TEMP: begin
          temp_result_r <= CONV_DATA_IN[9:0]; // [RULE6] [RULE22]
        end
        `SRC_AMP: begin
          amp_result_r <= CONV_DATA_IN; // [RULE7] [RULE22]
        end
        `SRC_AUX: begin
          aux_result_r <= CONV_DATA_IN; // [RULE8] [RULE22]
        end
        default: begin
          amp_result_r <= amp_result_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    case (REG_ADDR_IN)
      `OFS_MEASUREMENT_CONTROL: begin
        rdata_nxt = measurement_control_r;
      end
      `OFS_AMP_RESULT_LOW: begin
        rdata_nxt = amp_result_r[7:0]; // [RULE7]
      end
      `OFS_AMP_RESULT_HIGH: begin
        rdata_nxt = amp_result_r[15:8]; // [RULE7]
      end
      `OFS_AUX_RESULT_LOW: begin
        rdata_nxt = aux_result_r[7:0]; // [RULE8]
      end
      `OFS_AUX_RESULT_HIGH: begin
        rdata_nxt = aux_result_r[15:8]; // [RULE8]
      end
      `OFS_TEMP_RESULT_LOW: begin
        rdata_nxt = temp_result_r[7:0]; // [RULE6]
      end
      `OFS_TEMP_RESULT_HIGH: begin
        rdata_nxt = {6'h00, temp_result_r[9:8]}; // [RULE6]
      end
      `OFS_BIAS_SWITCH_CONNECT: begin
        rdata_nxt = bias_switch_connect_r;
      end
      `OFS_BIAS_LEVEL_SELECT: begin
        rdata_nxt = bias_level_select_r;
      end
      `OFS_INPUT_PATH_CONNECT: begin
        rdata_nxt = input_path_connect_r;
      end
      `OFS_BLOCK_POWER_CONTROL: begin
        rdata_nxt = block_power_control_r;
      end
      `OFS_BLOCK_CONTROL_REG: begin
        rdata_nxt = block_control_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Source match, one entry per route
  // ----------------------------------------
  genvar src_idx;

  generate
    for (src_idx = 0; src_idx < 3; src_idx = src_idx + 1) begin : g_src_match
      assign src_match[src_idx] = ({30'h00000000, source_select} == src_idx);
    end
  endgenerate

  // ----------------------------------------
  // Source routing and status
  // ----------------------------------------
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SRC_TEMP_OUT                  <= 1'b0;
      SRC_AMP_OUT                   <= 1'b0;
      SRC_AUX_OUT                   <= 1'b0;
      CONV_COMPLETE_OUT             <= 1'b0;
      INTERNAL_REFERENCE_SWITCH_OUT <= 1'b0;
    end else begin
      SRC_TEMP_OUT <= src_match[`SRC_TEMP]; // [RULE1]
      SRC_AMP_OUT  <= src_match[`SRC_AMP];  // [RULE2]
      SRC_AUX_OUT  <= src_match[`SRC_AUX];  // [RULE3]
      CONV_COMPLETE_OUT <= seq_done;
      INTERNAL_REFERENCE_SWITCH_OUT <=
        !block_control_r[`BIT_BIAS_REF_SEL]; // [RULE18]
    end
  end

  // ----------------------------------------
  // Analog control levels
  // ----------------------------------------
  assign LADDER_TO_TIA_SWITCH_OUT =
    bias_switch_connect_r[`BIT_LADDER_TO_TIA]; // [RULE9]
  assign LADDER_TO_POTENTIOSTAT_SWITCH_OUT =
    bias_switch_connect_r[`BIT_LADDER_TO_POT]; // [RULE10]
  assign TIA_SENSOR_INPUT_SELECT_OUT =
    input_path_connect_r[`BIT_TIA_SENSOR_SEL]; // [RULE11]
  assign POTENTIOSTAT_SENSOR_INPUT_SELECT_OUT =
    input_path_connect_r[`BIT_POT_SENSOR_SEL]; // [RULE12]
  assign LADDER_OUTPUT_SELECT_OUT =
    input_path_connect_r[`BIT_LADDER_OUT_SEL]; // [RULE13]
  assign GAIN_STAGE_ENABLE_OUT =
    input_path_connect_r[`BIT_GAIN_STAGE_EN]; // [RULE13]

  // ----------------------------------------
  // Bias ladder taps
  // ----------------------------------------
  assign TIA_BIAS_TAP_OUT          = bias_level_select_r[7:5]; // [RULE14]
  assign POTENTIOSTAT_BIAS_TAP_OUT = bias_level_select_r[4:0]; // [RULE14]

  // ----------------------------------------
  // Block power
  // ----------------------------------------
  assign BIAS_LADDER_POWER_OUT =
    block_power_control_r[`BIT_PWR_LADDER]; // [RULE15]
  assign TIA_POWER_OUT =
    block_power_control_r[`BIT_PWR_TIA]; // [RULE15]
  assign POTENTIOSTAT_POWER_OUT =
    block_power_control_r[`BIT_PWR_POT]; // [RULE15]
  assign OSCILLATOR_POWER_OUT =
    block_power_control_r[`BIT_PWR_OSCILLATOR]; // [RULE15]

  // ----------------------------------------
  // Block control fields
  // ----------------------------------------
  assign ELECTRODE_SHORTING_SWITCH_OUT =
    block_control_r[`BIT_SHORT_SWITCH]; // [RULE16]
  assign SENSOR_DIAGNOSTIC_OUT =
    block_control_r[`BIT_DIAGNOSTIC]; // [RULE17]
  assign GAIN_STAGE_TOPOLOGY_OUT =
    block_control_r[`BIT_TOPOLOGY]; // [RULE19]
  assign GAIN_STAGE_GAIN_OUT =
    block_control_r[`BIT_GAIN_HI:`BIT_GAIN_LO]; // [RULE20]
  assign CLOCK_RUN_OUT = block_control_r[`BIT_CLOCK_RUN];

endmodule

//--- rtl/conv_sequencer.v
// Purpose: Runs one converter request per start and reports completion
// Assumes: Converter done and data arrive on the system clock
// Notes:   Source is frozen for the whole conversion
`timescale 1ns/1ps
`include "afe_consts.vh"

module conv_sequencer (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        start_in,
  input  wire [1:0]  source_in,
  input  wire        conv_done_in,
  output reg         conv_req_out,
  output reg  [1:0]  conv_src_out,
  output reg         done_out,
  output wire        busy_out
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg state_r;
  reg state_nxt;

  assign busy_out = state_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_in) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (conv_done_in) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r      <= ST_IDLE;
      conv_req_out <= 1'b0;
      conv_src_out <= `SRC_TEMP;
      done_out     <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      done_out <= (state_r == ST_BUSY) && conv_done_in;
      if ((state_r == ST_IDLE) && start_in) begin
        conv_req_out <= 1'b1;
        conv_src_out <= source_in;
      end else if (conv_done_in) begin
        conv_req_out <= 1'b0;
      end
    end
  end

endmodule
